// File: common/pst_defs.svh
// Offsets, field positions, reset values and timing counts of the PWM steering block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
`ifndef PST_DEFS_SVH
`define PST_DEFS_SVH

`define PST_OFF_STEER_CTRL 12'h000
`define PST_OFF_UNIT_CFG 12'h004
`define PST_OFF_DEAD_BAND 12'h008
`define PST_OFF_STATUS 12'h00c

`define PST_STEER_RESET 5'h01
`define PST_UNIT_RESET 6'h00
`define PST_DB_RESET 7'h00

`define PST_BIT_SYNC 4
`define PST_MODE_PWM 2'h3
`define PST_CFG_SINGLE 2'h0

`define PST_CLK_NS 10
`define PST_TOSC_NS 10
`define PST_INSTR_CYC 4

`endif

// File: common/pst_pkg.sv
// Types shared by the PWM steering block.
// Assumes pst_defs.svh is included by users that need the numbers.
package pst_pkg;
    typedef struct packed {
        logic sync;
        logic [3:0] enable;
    } pst_steer_t;

    typedef struct packed {
        logic [1:0] config_sel;
        logic [3:0] mode_sel;
    } pst_unit_t;

    typedef enum logic [1:0] {
        PST_DB_IDLE,
        PST_DB_WAIT,
        PST_DB_ACTIVE
    } pst_db_state_t;
endpackage

// File: verilog/pst_steering.sv
// PWM output steering with polarity, sync update and dead-band delay, APB registers.
// Assumes i_pwm_raw and i_period_start come from core-clock logic; i_port_data likewise.
`timescale 1ns/1ns
`include "pst_defs.svh"

// How it works
// - Enabled outputs carry PWM with selected polarity.
// - Disabled outputs return to port data.
// - Steering only in PWM mode, single output.
// - Active edges delayed by dead-band instruction cycles.
module pst_steering (
    input wire logic i_core_clk, // System clock, 100 MHz.
    input wire logic i_sys_rst, // Synchronous reset, active high.
    input wire logic i_psel, // APB select.
    input wire logic i_penable, // APB enable.
    input wire logic i_pwrite, // APB write.
    input wire logic [11:0] i_paddr, // APB byte address.
    input wire logic [31:0] i_pwdata, // APB write data.
    input wire logic i_pwm_raw, // PWM waveform from the duty generator.
    input wire logic i_period_start, // One-cycle pulse at each PWM period start.
    input wire logic [3:0] i_port_data, // General-purpose port levels for pins A to D.
    output logic o_pready, // APB ready.
    output logic o_pslverr, // APB error on unmapped address.
    output logic [31:0] o_prdata, // APB read data.
    output logic [3:0] o_pwm_out // Pins D..A.
);
    localparam int TOSC_PER_INSTR = `PST_INSTR_CYC * `PST_TOSC_NS;
    localparam int INSTR_CLKS_I = (TOSC_PER_INSTR + `PST_CLK_NS - 1) / `PST_CLK_NS;
    localparam logic [2:0] INSTR_CLKS = 3'(INSTR_CLKS_I);

    pst_pkg::pst_steer_t steer_reg, steer_next;
    pst_pkg::pst_steer_t active_reg;
    pst_pkg::pst_unit_t unit_reg;
    logic [6:0] db_reg;
    pst_pkg::pst_db_state_t db_state_reg, db_state_next;
    logic [6:0] db_cnt_reg, db_cnt_next;
    logic [2:0] presc_reg;
    logic pwm_prev_reg;
    logic delayed_reg, delayed_next;
    logic pending_reg;
    logic [3:0] out_next;
    logic [31:0] rdata_next;

    wire logic access = i_psel && i_penable;
    wire logic sel_steer = (i_paddr == `PST_OFF_STEER_CTRL);
    wire logic sel_unit = (i_paddr == `PST_OFF_UNIT_CFG);
    wire logic sel_db = (i_paddr == `PST_OFF_DEAD_BAND);
    wire logic sel_stat = (i_paddr == `PST_OFF_STATUS);
    wire logic mapped = sel_steer || sel_unit || sel_db || sel_stat;
    wire logic wr_steer = access && i_pwrite && sel_steer;
    wire logic wr_unit = access && i_pwrite && sel_unit;
    wire logic wr_db = access && i_pwrite && sel_db;
    wire logic instr_tick = (presc_reg == INSTR_CLKS - 3'h1);
    wire logic steer_mode = (unit_reg.mode_sel[3:2] == `PST_MODE_PWM)
        && (unit_reg.config_sel == `PST_CFG_SINGLE);
    wire logic pwm_rise = i_pwm_raw && !pwm_prev_reg;
    wire logic pol_high = !unit_reg.mode_sel[1];
    wire logic apply_now = steer_reg.sync ? i_period_start : instr_tick;
    wire logic pwm_level = pol_high ? delayed_reg : !delayed_reg;

    assign steer_next = wr_steer ? pst_pkg::pst_steer_t'(i_pwdata[4:0]) : steer_reg;

    // Active edges wait db_reg instruction cycles; inactive edges pass at once.
    always_comb begin
        db_state_next = db_state_reg;
        db_cnt_next = db_cnt_reg;
        delayed_next = delayed_reg;
        unique case (db_state_reg)
            pst_pkg::PST_DB_IDLE: begin
                if (pwm_rise && db_reg == 7'h00) begin
                    delayed_next = 1'b1;
                    db_state_next = pst_pkg::PST_DB_ACTIVE;
                end else if (pwm_rise) begin
                    db_cnt_next = db_reg;
                    db_state_next = pst_pkg::PST_DB_WAIT;
                end
            end
            pst_pkg::PST_DB_WAIT: begin
                if (!i_pwm_raw) begin
                    db_state_next = pst_pkg::PST_DB_IDLE;
                end else if (instr_tick && db_cnt_reg == 7'h01) begin
                    delayed_next = 1'b1;
                    db_state_next = pst_pkg::PST_DB_ACTIVE;
                end else if (instr_tick) begin
                    db_cnt_next = db_cnt_reg - 7'h01;
                end
            end
            pst_pkg::PST_DB_ACTIVE: begin
                if (!i_pwm_raw) begin
                    delayed_next = 1'b0;
                    db_state_next = pst_pkg::PST_DB_IDLE;
                end
            end
        endcase
    end

    // Each pin takes the shaped PWM when steered, else its port level.
    generate
        for (genvar i = 0; i < 4; i++) begin : g_pin
            assign out_next[i] = (steer_mode && active_reg.enable[i])
                ? pwm_level : i_port_data[i];
        end
    endgenerate

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (sel_steer) begin
            rdata_next[4:0] = steer_reg;
        end else if (sel_unit) begin
            rdata_next[5:0] = unit_reg;
        end else if (sel_db) begin
            rdata_next[6:0] = db_reg;
        end else if (sel_stat) begin
            rdata_next[4:0] = active_reg;
            rdata_next[5] = steer_mode;
            rdata_next[6] = pending_reg;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            steer_reg <= `PST_STEER_RESET;
            unit_reg <= `PST_UNIT_RESET;
            db_reg <= `PST_DB_RESET;
        end else begin
            steer_reg <= steer_next;
            if (wr_unit) begin
                unit_reg <= i_pwdata[5:0];
            end
            if (wr_db) begin
                db_reg <= i_pwdata[6:0];
            end
        end
    end

    // The working copy of the steering bits follows at the chosen boundary.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            active_reg <= `PST_STEER_RESET;
            pending_reg <= 1'b0;
        end else if (apply_now) begin
            active_reg <= steer_reg;
            pending_reg <= wr_steer;
        end else begin
            pending_reg <= wr_steer || pending_reg;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            presc_reg <= 3'h0;
            db_state_reg <= pst_pkg::PST_DB_IDLE;
            db_cnt_reg <= 7'h00;
            delayed_reg <= 1'b0;
            pwm_prev_reg <= 1'b0;
        end else begin
            presc_reg <= instr_tick ? 3'h0 : presc_reg + 3'h1;
            db_state_reg <= db_state_next;
            db_cnt_reg <= db_cnt_next;
            delayed_reg <= delayed_next;
            pwm_prev_reg <= i_pwm_raw;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pwm_out <= 4'h0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !mapped;
            o_prdata <= rdata_next;
            o_pwm_out <= out_next;
        end
    end
endmodule

// File: tb/pst_steering_monitor.sv
// Checker for the PWM steering block ports.
// Assumes it is bound to pst_steering.
`timescale 1ns/1ns
module pst_steering_chk (
    input wire logic i_core_clk, // Clock.
    input wire logic i_sys_rst, // Reset.
    input wire logic i_psel, // Select.
    input wire logic i_penable, // Enable.
    input wire logic i_pwrite, // Write.
    input wire logic [11:0] i_paddr, // Address.
    input wire logic [31:0] i_pwdata, // Data.
    input wire logic [3:0] i_port_data, // Port.
    input wire logic o_pready, // Ready.
    input wire logic o_pslverr, // Error.
    input wire logic [3:0] o_pwm_out // Pins.
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    logic mode_reg;
    // Tracks whether the last unit write selected PWM mode with single output.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst)
            mode_reg <= 1'b0;
        else if (i_psel && i_penable && i_pwrite && i_paddr == 12'h004)
            mode_reg <= i_pwdata[5:2] == 4'h3;
    end
    sequence setup_s;
        i_psel && !i_penable;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> o_pready)
        else $error("no ready after setup");
    ready_idle_a: assert property (!i_psel |=> !o_pready)
        else $error("ready while idle");
    error_with_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    port_fallback_a: assert property (!mode_reg [*3] |-> o_pwm_out == $past(i_port_data))
        else $error("pins not on port data");
    mode_pins_a: assert property (!mode_reg [*2] ##0 $stable(i_port_data) |=> $stable(o_pwm_out))
        else $error("pins moved with steering off");
endmodule
bind pst_steering pst_steering_chk chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_port_data(i_port_data), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_pwm_out(o_pwm_out));

// File: tb/tb_top.sv
// Testbench for the PWM steering block.
// Assumes APB zero-wait answers and registered pins.
`timescale 1ns/1ns
module tb_top;
    logic i_core_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic i_pwm_raw = 0, i_period_start = 0, o_pready, o_pslverr, err;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata, rd;
    logic [3:0] i_port_data = 0, o_pwm_out;
    int mismatches = 0, total_checks = 0, n;
    always #5 i_core_clk = ~i_core_clk;
    pst_steering uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pwm_raw(i_pwm_raw), .i_period_start(i_period_start), .i_port_data(i_port_data),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_pwm_out(o_pwm_out));
    task automatic cyc(input int k);
        repeat (k) @(posedge i_core_clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        cyc(1);
        i_psel <= 1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        cyc(1);
        i_penable <= 1;
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rd = o_prdata;
        err = o_pslverr;
        if (o_pready !== 1'b1) begin
            mismatches++;
            $display("MISMATCH pready expected 1 seen %b", o_pready);
        end
        cyc(1);
        i_psel <= 0;
        i_penable <= 0;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        tally_and_finish;
    end
    initial begin
        cyc(2);
        i_sys_rst <= 0;
        apb(0, 12'h000, 0);
        chk("steer reset", 32'h1, rd);
        apb(0, 12'h010, 0);
        chk("unmapped", 1, err);
        i_port_data <= 4'ha;
        cyc(4);
        chk("mode off", 4'ha, o_pwm_out);
        $display("test registers done");
        i_port_data <= 4'h0;
        apb(1, 12'h000, 32'h5);
        apb(1, 12'h004, 32'hc);
        i_pwm_raw <= 1;
        cyc(8);
        chk("steer high", 4'h5, o_pwm_out);
        i_pwm_raw <= 0;
        cyc(4);
        chk("steer low", 4'h0, o_pwm_out);
        apb(1, 12'h004, 32'he);
        cyc(6);
        chk("inverted", 4'h5, o_pwm_out);
        apb(1, 12'h004, 32'h1c);
        cyc(3);
        chk("config 01", 4'h0, o_pwm_out);
        $display("test steering done");
        apb(1, 12'h004, 32'hc);
        apb(1, 12'h008, 32'h3);
        cyc(4);
        i_pwm_raw <= 1;
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (o_pwm_out[0] !== 1'b1 && n < 40);
        chk("dead band", 1, n > 8 && n < 16);
        cyc(1);
        i_port_data <= 4'h2;
        apb(1, 12'h000, 32'h11);
        cyc(8);
        chk("sync hold", 4'h7, o_pwm_out);
        apb(0, 12'h00c, 0);
        chk("status pending", 32'h65, rd);
        i_period_start <= 1;
        cyc(1);
        i_period_start <= 0;
        cyc(4);
        chk("sync apply", 4'h3, o_pwm_out);
        apb(1, 12'h000, 32'h0);
        cyc(8);
        chk("released", 4'h2, o_pwm_out);
        $display("test timing done");
        tally_and_finish;
    end
endmodule
